//--- dcsw_pkg.sv
// Package for the disc controller status word block.
// Assumes a single controller clock shared by all sequencer events.
package dcsw_pkg;
	localparam int STAT_W = 16;
	// Status word field positions (bit 0 is the word's LSB here)
	localparam int BIT_ERR_N = 0;
	localparam int BIT_RATE = 1;
	localparam int BIT_CKSUM = 2;
	localparam int BIT_PWR_OFF = 3;
	localparam int BIT_MPAR = 4;
	localparam int BIT_WPROT = 5;
	localparam int BIT_BUSY = 7;
	localparam int BIT_BUF_RDY_N = 8;
	localparam int BIT_EOD = 9;
	localparam int BIT_EOF = 10;
	localparam int BIT_EOR = 11;
	localparam logic [15:0] STAT_RESET = 16'h0101;
	// Terminate command bit that flags a memory parity abort
	localparam int TERM_MPAR_BIT = 7;

	// Events reported by the sequencers and command decoder
	typedef struct packed {
		logic xfer_start;
		logic is_write;
		logic eod_mark;
		logic eof_mark;
		logic xfer_done;
		logic rate_fault;
		logic cksum_fault;
		logic rd_sector_end;
		logic rd_eor;
		logic rd_eod;
		logic rd_eof;
		logic terminate;
		logic [15:0] term_word;
	} dcsw_evt_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_FILL = 3'b100
	} dcsw_state_t;
endpackage : dcsw_pkg

//--- dcsw_status.sv
// Status word register bank of the fixed-head disc controller.
// Assumes sequencer events are single-cycle pulses on ref_clk.
//
// Overview of operation
// - Bit 0 low when bits 1-4 set
// - Rate fault sets bit 1, stops transfer
// - Write rate fault pads sector with zeros
// - Checksum fault sets bit 2, stops read
// - Unit power off sets bit 3
// - Memory parity abort sets bit 4
// - Protected track sets bit 5
// - Bit 7 set while transfer executing
// - Head select leaves busy unchanged
// - Bit 8 low when buffer ready
// - Bit 9 reports end-of-device mark
// - Bit 10 reports end-of-file mark
// - Bit 11 reports end of record
// - Read/write accept clears old status
// - Terminate with bit 7 sets bit 4
// - Unit select keeps status, not busy
// - Status word driven on status read
`timescale 1ns/1ps
module dcsw_status (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire dcsw_pkg::dcsw_evt_t evt,
	input wire logic head_select,
	input wire logic unit_select,
	input wire logic unit_power_off,
	input wire logic track_protected,
	input wire logic buffer_avail,
	input wire logic sector_end,
	input wire logic status_input_instruction,
	output logic [15:0] status_data,
	output logic status_valid,
	output logic stop_transfer,
	output logic fill_zeros,
	output logic [15:0] disc_status_word
);
	dcsw_pkg::dcsw_state_t state_q;
	logic rate_fault_flag;
	logic checksum_fault_flag;
	logic memory_parity_abort_flag;
	logic end_of_device_flag;
	logic end_of_file_flag;
	logic end_of_record_flag;
	logic wr_q;
	logic eod_req_q;
	logic eof_req_q;
	logic [15:0] status_q;
	logic clr;
	logic term_mpar;

	// Shared by the word assembly and the summary checks
	function automatic logic err_any(
		input logic rate,
		input logic cksum,
		input logic pwr_off,
		input logic mpar
	);
		return rate || cksum || pwr_off || mpar;
	endfunction : err_any

	// Only a read or write accept clears; head and unit select never reach here
	assign clr = evt.xfer_start;
	assign term_mpar = evt.terminate && evt.term_word[dcsw_pkg::TERM_MPAR_BIT];

	// Transfer sequencing: busy covers transfer and zero padding
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_q <= dcsw_pkg::ST_IDLE;
		end else begin
			case (state_q)
				dcsw_pkg::ST_IDLE: begin
					if (evt.xfer_start)
						state_q <= dcsw_pkg::ST_XFER;
				end
				dcsw_pkg::ST_XFER: begin
					if (evt.rate_fault && wr_q)
						state_q <= dcsw_pkg::ST_FILL;
					else if (evt.xfer_done)
						state_q <= dcsw_pkg::ST_IDLE;
				end
				dcsw_pkg::ST_FILL: begin
					if (sector_end)
						state_q <= dcsw_pkg::ST_IDLE;
				end
				default: state_q <= dcsw_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wr_q <= 1'b0;
			eod_req_q <= 1'b0;
			eof_req_q <= 1'b0;
		end else if (evt.xfer_start) begin
			wr_q <= evt.is_write;
			eod_req_q <= evt.is_write && evt.eod_mark;
			eof_req_q <= evt.is_write && evt.eof_mark;
		end
	end

	// Stop pulse for the sequencers; padding continues in fill state
	assign stop_transfer = (state_q == dcsw_pkg::ST_XFER) &&
		(evt.rate_fault || (evt.cksum_fault && !wr_q));
	assign fill_zeros = (state_q == dcsw_pkg::ST_FILL);

	// Error flags: a set in the clearing cycle still wins
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rate_fault_flag <= 1'b0;
			checksum_fault_flag <= 1'b0;
			memory_parity_abort_flag <= 1'b0;
		end else begin
			if (evt.rate_fault)
				rate_fault_flag <= 1'b1;
			else if (clr)
				rate_fault_flag <= 1'b0;
			if (evt.cksum_fault && !wr_q)
				checksum_fault_flag <= 1'b1;
			else if (clr)
				checksum_fault_flag <= 1'b0;
			if (term_mpar)
				memory_parity_abort_flag <= 1'b1;
			else if (clr)
				memory_parity_abort_flag <= 1'b0;
		end
	end

	// Record marks from reads, or from the completed write
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			end_of_device_flag <= 1'b0;
			end_of_file_flag <= 1'b0;
			end_of_record_flag <= 1'b0;
		end else begin
			if (evt.xfer_done && wr_q) begin
				end_of_device_flag <= eod_req_q;
				end_of_file_flag <= eof_req_q;
				end_of_record_flag <= 1'b1;
			end else if (evt.rd_sector_end && !wr_q) begin
				end_of_device_flag <= evt.rd_eod;
				end_of_file_flag <= evt.rd_eof;
				end_of_record_flag <= evt.rd_eor;
			end else if (clr) begin
				end_of_device_flag <= 1'b0;
				end_of_file_flag <= 1'b0;
				end_of_record_flag <= 1'b0;
			end
		end
	end

	// Assembled word; power-off and protection are live levels
	always_comb begin
		disc_status_word = 16'h0000;
		disc_status_word[dcsw_pkg::BIT_RATE] = rate_fault_flag;
		disc_status_word[dcsw_pkg::BIT_CKSUM] = checksum_fault_flag;
		disc_status_word[dcsw_pkg::BIT_PWR_OFF] = unit_power_off;
		disc_status_word[dcsw_pkg::BIT_MPAR] = memory_parity_abort_flag;
		disc_status_word[dcsw_pkg::BIT_ERR_N] =
			!err_any(rate_fault_flag, checksum_fault_flag, unit_power_off, memory_parity_abort_flag);
		disc_status_word[dcsw_pkg::BIT_WPROT] = track_protected;
		disc_status_word[dcsw_pkg::BIT_BUSY] = (state_q != dcsw_pkg::ST_IDLE);
		disc_status_word[dcsw_pkg::BIT_BUF_RDY_N] = !buffer_avail;
		disc_status_word[dcsw_pkg::BIT_EOD] = end_of_device_flag;
		disc_status_word[dcsw_pkg::BIT_EOF] = end_of_file_flag;
		disc_status_word[dcsw_pkg::BIT_EOR] = end_of_record_flag;
	end

	// Captured on the status read instruction cycle; valid and driven the next cycle
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			status_q <= dcsw_pkg::STAT_RESET;
			status_valid <= 1'b0;
		end else begin
			status_valid <= status_input_instruction;
			if (status_input_instruction)
				status_q <= disc_status_word;
		end
	end
	assign status_data = status_q;

	AST_ERR_SUM: assert property (@(posedge ref_clk) disable iff (!nrst)
		err_any(rate_fault_flag, checksum_fault_flag, unit_power_off, memory_parity_abort_flag)
		|-> !disc_status_word[dcsw_pkg::BIT_ERR_N]) else $error("error summary not low");
	AST_RATE_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
		evt.rate_fault |=> rate_fault_flag) else $error("rate fault not recorded");
	AST_FILL: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == dcsw_pkg::ST_XFER && wr_q && evt.rate_fault) |=> fill_zeros) else $error("no zero fill");
	AST_CKSUM_STOP: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == dcsw_pkg::ST_XFER && !wr_q && evt.cksum_fault) |-> stop_transfer ##1 checksum_fault_flag)
		else $error("checksum fault handling wrong");
	AST_MPAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		term_mpar |=> disc_status_word[4] && !disc_status_word[0]) else $error("parity abort not shown");
	AST_BUSY: assert property (@(posedge ref_clk) disable iff (!nrst)
		(evt.xfer_start && state_q == dcsw_pkg::ST_IDLE) |=> disc_status_word[7]) else $error("busy not set");
	AST_HEAD_SEL: assert property (@(posedge ref_clk) disable iff (!nrst)
		((head_select || unit_select) && !evt.xfer_start && state_q == dcsw_pkg::ST_IDLE)
		|=> !disc_status_word[7]) else $error("select made device busy");
	AST_WR_EOR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(evt.xfer_done && wr_q) |=> end_of_record_flag) else $error("end of record missing after write");
	AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clr && !evt.rate_fault) |=> !rate_fault_flag) else $error("status not cleared");
	AST_UNUSED: assert property (@(posedge ref_clk) disable iff (!nrst)
		disc_status_word[6] == 1'b0 && disc_status_word[15:12] == 4'h0) else $error("unused bits nonzero");
	AST_RD: assert property (@(posedge ref_clk) disable iff (!nrst)
		status_input_instruction |=> status_valid && status_data == $past(disc_status_word))
		else $error("status read wrong");

	AST_ERR_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		!err_any(rate_fault_flag, checksum_fault_flag, unit_power_off, memory_parity_abort_flag)
		|-> disc_status_word[dcsw_pkg::BIT_ERR_N])
		else $error("error summary low without error");

	AST_RATE_STOP: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == dcsw_pkg::ST_XFER && evt.rate_fault)
		|-> stop_transfer)
		else $error("rate fault did not stop transfer");

	AST_FILL_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(fill_zeros && !sector_end)
		|=> fill_zeros)
		else $error("zero fill ended before sector end");

	AST_FILL_END: assert property (@(posedge ref_clk) disable iff (!nrst)
		(fill_zeros && sector_end)
		|=> !fill_zeros && !disc_status_word[dcsw_pkg::BIT_BUSY])
		else $error("zero fill did not end at sector end");

	AST_CKSUM_CLR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clr && !(evt.cksum_fault && !wr_q))
		|=> !checksum_fault_flag)
		else $error("checksum fault not cleared");

	AST_PWR_RD: assert property (@(posedge ref_clk) disable iff (!nrst)
		status_input_instruction
		|=> status_data[dcsw_pkg::BIT_PWR_OFF] == $past(unit_power_off))
		else $error("power off bit wrong in read word");

	AST_MPAR_CLR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clr && !term_mpar)
		|=> !memory_parity_abort_flag)
		else $error("parity abort not cleared");

	AST_WPROT_RD: assert property (@(posedge ref_clk) disable iff (!nrst)
		status_input_instruction
		|=> status_data[dcsw_pkg::BIT_WPROT] == $past(track_protected))
		else $error("protect bit wrong in read word");

	AST_BUSY_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == dcsw_pkg::ST_XFER && !evt.xfer_done)
		|=> disc_status_word[dcsw_pkg::BIT_BUSY])
		else $error("busy dropped during transfer");

	AST_BUSY_END: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == dcsw_pkg::ST_XFER && evt.xfer_done && !(evt.rate_fault && wr_q))
		|=> !disc_status_word[dcsw_pkg::BIT_BUSY])
		else $error("busy stuck after transfer");

	AST_BUF_RDY: assert property (@(posedge ref_clk) disable iff (!nrst)
		status_input_instruction
		|=> status_data[dcsw_pkg::BIT_BUF_RDY_N] == !$past(buffer_avail))
		else $error("buffer ready bit wrong in read word");

	AST_WR_EOD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(evt.xfer_done && wr_q)
		|=> end_of_device_flag == $past(eod_req_q))
		else $error("end of device wrong after write");

	AST_RD_EOD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(evt.rd_sector_end && !wr_q)
		|=> end_of_device_flag == $past(evt.rd_eod))
		else $error("end of device wrong after read");

	AST_WR_EOF: assert property (@(posedge ref_clk) disable iff (!nrst)
		(evt.xfer_done && wr_q)
		|=> end_of_file_flag == $past(eof_req_q))
		else $error("end of file wrong after write");

	AST_RD_EOF: assert property (@(posedge ref_clk) disable iff (!nrst)
		(evt.rd_sector_end && !wr_q)
		|=> end_of_file_flag == $past(evt.rd_eof))
		else $error("end of file wrong after read");

	AST_RD_EOR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(evt.rd_sector_end && !wr_q)
		|=> end_of_record_flag == $past(evt.rd_eor))
		else $error("end of record wrong after read");

	AST_CLR_MARKS: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clr && !evt.rd_sector_end && !evt.xfer_done)
		|=> !end_of_device_flag && !end_of_file_flag && !end_of_record_flag)
		else $error("record marks not cleared");

	AST_SEL_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
		(unit_select && !evt.xfer_start && !evt.rate_fault && !evt.cksum_fault && !evt.terminate)
		|=> $stable(rate_fault_flag) && $stable(checksum_fault_flag) && $stable(memory_parity_abort_flag))
		else $error("unit select changed status");

	AST_VALID_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
		!status_input_instruction
		|=> !status_valid)
		else $error("answer without status read");

	AST_RD_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!status_input_instruction
		|=> $stable(status_data))
		else $error("read word changed without status read");
endmodule : dcsw_status

//--- dcsw_host_model.sv
// Host side model: raises status reads and captures answered words.
// Assumes the answer follows each taken request by exactly one cycle.
`timescale 1ns/1ps
module dcsw_host_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic rd_go,
	input wire logic [15:0] status_data,
	input wire logic status_valid,
	output logic status_input_instruction,
	output logic [15:0] last_word,
	output int n_words,
	output int n_late
);
	logic req_q;
	assign status_input_instruction = rd_go;
	// Counting waits for reset, where the answer flop is still unknown
	always @(posedge ref_clk) begin
		if (!nrst) begin
			req_q <= 1'b0;
			n_words <= 0;
			n_late <= 0;
		end else begin
			req_q <= rd_go;
			// Early or missing answer counts as a protocol slip
			if (status_valid !== req_q) n_late <= n_late + 1;
			if (status_valid === 1'b1) begin
				last_word <= status_data;
				n_words <= n_words + 1;
			end
		end
	end
endmodule : dcsw_host_model

//--- disc_controller_status_word_tb_top.sv
// Self-checking bench for the status word block.
// Assumes the package, the block and the host model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module disc_controller_status_word_tb_top;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	dcsw_pkg::dcsw_evt_t evt = '0;
	logic hs = 1'b0, pwr = 1'b0, prot = 1'b0, buf_ok = 1'b0, sec_end = 1'b0, rd_go = 1'b0;
	logic sii, status_valid, stop_transfer, fill_zeros;
	logic [15:0] status_data, word, last_word;
	int n_words, n_late, mismatches = 0, comparisons = 0;
	bit rate, cks, mpar, end_of_device_mark, eof, end_of_record_mark, busy, fill, wr, meod, meof;
	int seq[] = '{1, 9, 0, 3, 1, 4, 0, 0, 8, 9, 2, 6, 5, 3, 7, 7, 7, 7, 2, 4, 6, 3, 1, 9, 3};
	always #2 ref_clk = ~ref_clk;
	dcsw_status dut_u (.ref_clk(ref_clk), .nrst(nrst), .evt(evt), .head_select(hs), .unit_select(hs),
		.unit_power_off(pwr), .track_protected(prot), .buffer_avail(buf_ok), .sector_end(sec_end),
		.status_input_instruction(sii), .status_data(status_data), .status_valid(status_valid),
		.stop_transfer(stop_transfer), .fill_zeros(fill_zeros), .disc_status_word(word));
	dcsw_host_model host_u (.ref_clk(ref_clk), .nrst(nrst), .rd_go(rd_go), .status_data(status_data),
		.status_valid(status_valid), .status_input_instruction(sii), .last_word(last_word),
		.n_words(n_words), .n_late(n_late));
	function automatic logic [15:0] expw();
		return {4'h0, end_of_record_mark, eof, end_of_device_mark, !buf_ok, busy, 1'b0, prot, mpar, pwr, cks, rate, !(rate | cks | pwr | mpar)};
	endfunction : expw
	task automatic results();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	task automatic step(input int k);
		dcsw_pkg::dcsw_evt_t e;
		e = '0;
		{e.eod_mark, e.eof_mark, e.rd_eor, e.rd_eod, e.rd_eof} = 5'($urandom);
		e.term_word = 16'($urandom);
		e.xfer_start = (k == 1 || k == 2);
		e.is_write = (k == 1);
		e.xfer_done = (k == 3);
		e.rate_fault = (k == 4);
		e.cksum_fault = (k == 5);
		e.rd_sector_end = (k == 6);
		e.terminate = (k == 7);
		@(negedge ref_clk);
		{pwr, prot, buf_ok} = 3'($urandom);
		evt = e;
		sec_end = (k == 8);
		hs = (k == 9);
		#1;
		`CHK(stop_transfer, busy & !fill & (e.rate_fault | e.cksum_fault & !wr))
		if (e.xfer_start) {rate, cks, mpar, end_of_device_mark, eof, end_of_record_mark, busy, wr, meod, meof} = {6'h0, 1'b1, e.is_write, e.eod_mark, e.eof_mark};
		if (e.rate_fault) rate = 1'b1;
		// Zero padding only starts from a running write
		if (e.rate_fault && busy && !fill) fill = wr;
		if (e.cksum_fault && !wr) cks = 1'b1;
		if (e.rd_sector_end && !wr) {end_of_record_mark, end_of_device_mark, eof} = {e.rd_eor, e.rd_eod, e.rd_eof};
		if (e.xfer_done && !fill) busy = 1'b0;
		if (e.xfer_done && wr) {end_of_record_mark, end_of_device_mark, eof} = {1'b1, meod, meof};
		if (e.terminate && e.term_word[dcsw_pkg::TERM_MPAR_BIT]) mpar = 1'b1;
		if (k == 8 && fill) {fill, busy} = 2'b00;
		@(negedge ref_clk);
		evt = '0;
		{sec_end, hs} = 2'b00;
		#1;
		`CHK(word, expw())
		`CHK(fill_zeros, fill)
	endtask : step
	initial begin
		void'($urandom(32'hFCCB0AF1));
		repeat (8) @(negedge ref_clk);
		nrst = 1'b1;
		#1;
		`CHK(word, 16'h0101)
		`CHK(status_data, 16'h0101)
		for (int p = 0; p < 3; p++) begin
			foreach (seq[i]) step(seq[i]);
			@(negedge ref_clk);
			rd_go = 1'b1;
			repeat (2) @(negedge ref_clk);
			rd_go = 1'b0;
			for (int w = 0; w < 10 && n_words < 2 * p + 2; w++) @(negedge ref_clk);
			if (n_words < 2 * p + 2) begin
				mismatches++;
				results();
			end
			`CHK(last_word, expw())
			`CHK(n_late, 0)
			$display("Pass %0d finished", p);
		end
		results();
	end
endmodule : disc_controller_status_word_tb_top
